// File: bench/sac_io_peer.sv
`timescale 1ns/1ps
module sac_io_peer #(parameter int MS_CYC = 10)
(
    // Bench command
    input wire logic clk_sys,
    input wire logic start,
    input wire logic [12:0] holdMs,
    // Line
    input wire logic ioOut,
    input wire logic ioOeN,
    output logic ioIn
);
    int left = 0;
    // Released line falls to the pull-down, never holds the last level
    assign ioIn = (left > 0) || (ioOut && !ioOeN);
    always @(posedge clk_sys)
    begin
        if (start)
            left <= holdMs * MS_CYC;
        else if (left > 0)
            left <= left - 1;
    end
endmodule

// File: bench/sac_props.sv
`timescale 1ns/1ps
module sac_props
    import sac_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Watched pins
    input wire logic testIn,
    input wire logic lowBatt,
    input wire logic ioOut,
    input wire logic ioOeN,
    input wire logic ioDischarge,
    input wire logic memIndicator,
    input wire sac_nv_cmd_t nvCmd,
    input wire logic nvAck
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_io_drive: assert property (ioOut |-> !ioOeN)
        else $error("io driven without enable");
    a_dump_start: assert property ($fell(ioOut) |-> ##[0:3] ioDischarge)
        else $error("no discharge after alarm");
    a_dump_hold: assert property ($rose(ioDischarge) |=> ioDischarge[*8])
        else $error("discharge too short");
    a_test_exit: assert property ($rose(testIn) && ioOut |-> ##[1:3] !ioOut)
        else $error("test did not end alarm");
    a_flash_len: assert property ($rose(memIndicator) |=> memIndicator[*8])
        else $error("memory flash too short");
    a_batt_mask: assert property (lowBatt[*3] |-> !memIndicator)
        else $error("memory flash on low battery");
    a_nv_hold: assert property (nvCmd.req && !nvAck |=> nvCmd.req)
        else $error("store request dropped");
    a_nv_order: assert property (nvCmd.req && !nvCmd.write && nvAck
        |-> ##[1:4] (nvCmd.req && nvCmd.write))
        else $error("no store write after read");
endmodule
bind sac_top sac_props i_props (.*);

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top import sac_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, peerGo = 1'b0;
    logic testIn = 1'b0, lowBatt = 1'b0, measValid = 1'b0, nvAck = 1'b0;
    logic [5:0] measCode = 6'h00;
    logic [8:0] nvRdata = 9'h104;
    logic [12:0] peerMs = 13'h0;
    logic ioIn, ioOut, ioOeN, ioDischarge, hornOn, redIndicator, memIndicator;
    sac_nv_cmd_t nvCmd;
    int numErrors = 0, compares = 0;
    always #5 clk_sys = ~clk_sys;
    sac_top #(.TICK_CYC(17'hA), .HUSH_MS(20'h32), .GROUP_MS(16'hBB8), .MEM_SHOW_S(17'h5),
        .AGE_STEP_S(21'h3)) i_dut (.*);
    sac_io_peer #(.MS_CYC(10)) i_peer (.clk_sys, .start(peerGo), .holdMs(peerMs), .ioOut,
        .ioOeN, .ioIn);
    // Store answers every request one cycle later
    always @(posedge clk_sys)
        nvAck <= nvCmd.req && !nvAck;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            numErrors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdReg(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic peer(input logic [12:0] ms);
        peerMs <= ms;
        peerGo <= 1'b1;
        tick(1);
        peerGo <= 1'b0;
    endtask
    task automatic closeOut;
        if (numErrors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        tick(16);
        rst <= 1'b0;
        wr(8'h00, 32'h5, 4'hF);
        chk(4'(rr), 4'h0);
        rdReg(8'h20);
        chk(4'(rr), 4'h2);
        repeat (3)
        begin
            measValid <= 1'b1;
            measCode <= 6'h3F;
            tick(1);
            measValid <= 1'b0;
            tick(3);
        end
        chk({2'h0, ioOut, ioOeN}, 4'h2);
        tick(4000);
        rdReg(8'h0C);
        chk({rd[7], rd[2:0]}, 4'h2);
        testIn <= 1'b1;
        tick(6);
        chk({2'h0, ioOut, ioDischarge}, 4'h1);
        tick(144);
        chk(4'(hornOn), 4'h0);
        tick(2400);
        chk(4'(hornOn), 4'h1);
        rdReg(8'h0C);
        chk(4'(rd[4]), 4'h1);
        testIn <= 1'b0;
        tick(4);
        rdReg(8'h0C);
        chk(4'(rd[3]), 4'h1);
        tick(600);
        rdReg(8'h0C);
        chk(4'(rd[4:3]), 4'h2);
        peer(13'hC8);
        tick(2500);
        rdReg(8'h0C);
        chk(4'(rd[7]), 4'h0);
        peer(13'h190);
        tick(4000);
        rdReg(8'h0C);
        chk({rd[7], rd[2:0]}, 4'hC);
        chk({2'h0, hornOn, redIndicator}, 4'h2);
        tick(4000);
        lowBatt <= 1'b1;
        tick(10000);
        lowBatt <= 1'b0;
        tick(12000);
        rdReg(8'h0C);
        chk(4'(rd[5]), 4'h1);
        testIn <= 1'b1;
        tick(20);
        testIn <= 1'b0;
        tick(20);
        rdReg(8'h0C);
        chk(4'(rd[4]), 4'h0);
        wr(8'h04, 32'hFFFF_FFFF, 4'h1);
        chk(4'(rr), 4'h0);
        rdReg(8'h04);
        chk(rd, 32'h1030_183F);
        wr(8'h0C, 32'h0, 4'hF);
        chk(4'(rr), 4'h2);
        closeOut;
    end
    initial
    begin
        tick(60000);
        numErrors++;
        closeOut;
    end
endmodule

// File: logic/sac_top.sv
`timescale 1ns/1ps
`include "sac_cfg.svh"
// Functional notes
// R1: Local alarm drives interconnect high at once via current source.
// R2: Interconnect input ignored while in local alarm.
// R3: After local alarm ends, pull-down discharge on for 1.3 s.
// R4: Filtered remote high enters remote alarm: horn on, red off.
// R5: Remote high accepted after 336 ms filter; sender holds long enough.
// R6: Test during local alarm leaves alarm at once, horn silenced.
// R7: Test release starts nine-minute hush using hush limit.
// R8: Hush flashes red 10 ms every 10 s.
// R9: Cancel option ends hush on smoke, remote alarm, or test.
// R10: Memory latch set when local alarm ends.
// R11: Latched memory flashes three 10 ms, 1.3 s apart, every 43 s.
// R12: Memory flashing stops after 24 hours; latch stays set.
// R13: Test held with latch set chirps horn 10 ms every 250 ms.
// R14: Press and release of test clears a set memory latch.
// R15: Low battery suppresses memory flash pattern.
// R16: Every 14 days with option, read, increment, store age count.
// R17: Age at ten years gives three 10 ms pulses 330 ms apart per 43 s.
// R18: End-of-life pulses sit 20 s from low battery warning slot.
// R19: Drift option averages 64 clean samples over 12 hours.
// R20: Drift is average minus calibration base; all four limits offset.
// R21: Drift sampling paused during hush, local or remote alarm.
// R22: Measurements and limits are 6-bit codes, 1/63 of full scale.
// R23: Three consecutive smoke hits enter local alarm, horn, interconnect.
// R24: Hush end restores normal limit and stops hush flashes.
module sac_top
    import sac_pkg::*;
#(
    parameter logic [16:0] TICK_CYC = 17'(`SAC_MS_NS / `SAC_CLK_NS),
    parameter logic [19:0] HUSH_MS = 20'(`SAC_HUSH_MS),
    parameter logic [15:0] GROUP_MS = 16'(`SAC_GROUP_MS),
    parameter logic [16:0] MEM_SHOW_S = 17'(`SAC_MEM_SHOW_S),
    parameter logic [20:0] AGE_STEP_S = 21'(`SAC_AGE_STEP_S),
    parameter logic [15:0] DRIFT_SPAN_S = 16'(`SAC_DRIFT_SPAN_S)
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Detector inputs
    input wire logic testIn,
    input wire logic lowBatt,
    input wire logic measValid,
    input wire logic [5:0] measCode,
    // Interconnect pin
    input wire logic ioIn,
    output logic ioOut,
    output logic ioOeN,
    output logic ioDischarge,
    // Indicators and horn
    output logic hornOn,
    output logic redIndicator,
    output logic memIndicator,
    // Nonvolatile store
    output sac_nv_cmd_t nvCmd,
    input wire logic nvAck,
    input wire logic [8:0] nvRdata
);

    function automatic logic inWin(input logic [15:0] ph, input logic [15:0] start);
        return (ph >= start) && (ph < start + 16'(`SAC_FLASH_MS));
    endfunction

    function automatic logic [5:0] adjLim(input logic [5:0] lim, input logic [6:0] d);
        logic [7:0] t;
        t = {2'b00, lim} + {d[6], d};
        if (t[7])
            return 6'h00;
        else if (t > 8'h3F)
            return 6'h3F;
        return t[5:0];
    endfunction

    function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    // ----------------------------------------
    // Millisecond and second ticks
    // ----------------------------------------
    logic [16:0] preCnt;
    logic [9:0] msCnt;
    wire msTick = (preCnt == TICK_CYC - 17'h1);
    wire secTick = msTick && (msCnt == 10'(`SAC_SEC_MS - 1));

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            preCnt <= 17'h0;
            msCnt <= 10'h0;
        end
        else
        begin
            preCnt <= msTick ? 17'h0 : preCnt + 17'h1;
            if (msTick)
                msCnt <= secTick ? 10'h0 : msCnt + 10'h1;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [2:0] ctrl;
    logic [31:0] limWord;
    logic [5:0] calBase;
    sac_alarm_t state;
    sac_alarm_t next_state;
    logic hush;
    logic memLatch;
    logic remoteOk;
    logic [8:0] ageCount;
    logic [6:0] drift;
    logic memExpired;

    wire eolEn = ctrl[`SAC_CTRL_EOL];
    wire driftEn = ctrl[`SAC_CTRL_DRIFT];
    wire hushCancelOpt = ctrl[`SAC_CTRL_HCAN];
    wire sac_limits_t rawLim = limWord;
    wire [6:0] useDrift = driftEn ? drift : 7'h0;
    sac_limits_t lim;

    always_comb
    begin
        lim = '0;
        lim.norm = adjLim(rawLim.norm, useDrift); // [R20]
        lim.hyst = adjLim(rawLim.hyst, useDrift); // [R20]
        lim.hush = adjLim(rawLim.hush, useDrift); // [R20]
        lim.cht = adjLim(rawLim.cht, useDrift); // [R20] [R22]
    end

    // ----------------------------------------
    // Detection and alarm state
    // ----------------------------------------
    logic testPrev;
    logic [1:0] hitCnt;
    logic [1:0] clrCnt;
    logic testQuit;
    wire testRise = testIn && !testPrev;
    wire testFall = !testIn && testPrev;
    wire isLocal = (state == SAC_LOCAL);
    wire [5:0] selLim = isLocal ? lim.hyst : testIn ? lim.cht : hush ? lim.hush : lim.norm;
    wire smokeHit = measValid && (measCode > selLim); // [R22] [R24]
    wire noSmoke = measValid && !smokeHit;
    wire enterLocal = smokeHit && (hitCnt == 2'h2) && !isLocal && !testQuit; // [R23]
    wire localExit = isLocal && (next_state != SAC_LOCAL);

    always_comb
    begin
        next_state = state;
        case (state)
            SAC_STANDBY:
                if (enterLocal)
                    next_state = SAC_LOCAL;
                else if (remoteOk)
                    next_state = SAC_REMOTE; // [R4]
            SAC_LOCAL:
                if (testRise)
                    next_state = SAC_STANDBY; // [R6]
                else if (noSmoke && clrCnt == 2'h2)
                    next_state = SAC_STANDBY;
            SAC_REMOTE:
                if (enterLocal)
                    next_state = SAC_LOCAL;
                else if (!remoteOk)
                    next_state = SAC_STANDBY;
            default:
                next_state = SAC_STANDBY;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= SAC_STANDBY;
            testPrev <= 1'b0;
            hitCnt <= 2'h0;
            clrCnt <= 2'h0;
            testQuit <= 1'b0;
        end
        else
        begin
            state <= next_state;
            testPrev <= testIn;
            if (next_state != state || noSmoke)
                hitCnt <= 2'h0;
            else if (smokeHit && hitCnt != 2'h3)
                hitCnt <= hitCnt + 2'h1; // [R23]
            if (next_state != state || smokeHit)
                clrCnt <= 2'h0;
            else if (noSmoke && clrCnt != 2'h3)
                clrCnt <= clrCnt + 2'h1;
            if (isLocal && testRise)
                testQuit <= 1'b1; // [R6]
            else if (testFall)
                testQuit <= 1'b0;
        end
    end

    // ----------------------------------------
    // Interconnect filter and discharge
    // ----------------------------------------
    logic [8:0] filtCnt;
    logic [10:0] dischCnt;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            filtCnt <= 9'h0;
            remoteOk <= 1'b0;
            dischCnt <= 11'h0;
        end
        else
        begin
            // Up/down count lets pulsed senders with majority duty pass
            if (isLocal)
                filtCnt <= 9'h0; // [R2]
            else if (msTick && ioIn && filtCnt != 9'(`SAC_IO_FILT_MS))
                filtCnt <= filtCnt + 9'h1; // [R5]
            else if (msTick && !ioIn && filtCnt != 9'h0)
                filtCnt <= filtCnt - 9'h1;
            if (isLocal || filtCnt == 9'h0)
                remoteOk <= 1'b0; // [R2]
            else if (filtCnt == 9'(`SAC_IO_FILT_MS))
                remoteOk <= 1'b1; // [R5]
            if (localExit)
                dischCnt <= 11'(`SAC_DISCH_MS); // [R3]
            else if (msTick && dischCnt != 11'h0)
                dischCnt <= dischCnt - 11'h1;
        end
    end

    // ----------------------------------------
    // Hush
    // ----------------------------------------
    logic [19:0] hushCnt;
    logic [13:0] hushPh;
    logic skipHush;
    wire hushCancel = hushCancelOpt && hush && (smokeHit || remoteOk || testRise); // [R9]

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            hush <= 1'b0;
            hushCnt <= 20'h0;
            hushPh <= 14'h0;
            skipHush <= 1'b0;
        end
        else
        begin
            if (hushCancel && testRise)
                skipHush <= 1'b1;
            else if (testFall)
                skipHush <= 1'b0;
            if (testFall && !skipHush)
            begin
                hush <= 1'b1; // [R7]
                hushCnt <= HUSH_MS;
                hushPh <= 14'h0;
            end
            else if (hushCancel || (hush && msTick && hushCnt == 20'h1))
                hush <= 1'b0; // [R24]
            else if (hush && msTick)
            begin
                hushCnt <= hushCnt - 20'h1;
                hushPh <= (hushPh == 14'(`SAC_HUSH_PER_MS - 1)) ? 14'h0 : hushPh + 14'h1;
            end
        end
    end

    // ----------------------------------------
    // Alarm memory
    // ----------------------------------------
    logic memArmed;
    logic [16:0] memSec;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            memLatch <= 1'b0;
            memArmed <= 1'b0;
            memSec <= 17'h0;
            memExpired <= 1'b0;
        end
        else
        begin
            if (testRise)
                memArmed <= memLatch;
            if (localExit)
            begin
                memLatch <= 1'b1; // [R10]
                memSec <= 17'h0;
                memExpired <= 1'b0;
            end
            else if (testFall && memArmed)
                memLatch <= 1'b0; // [R14]
            else if (memLatch && secTick && !memExpired)
            begin
                memSec <= memSec + 17'h1;
                memExpired <= (memSec == MEM_SHOW_S - 17'h1); // [R12]
            end
        end
    end

    // ----------------------------------------
    // Pattern phases
    // ----------------------------------------
    logic [15:0] grpPh;
    logic [7:0] chirpPh;
    logic [8:0] almPh;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            grpPh <= 16'h0;
            chirpPh <= 8'h0;
            almPh <= 9'h0;
        end
        else
        begin
            if (msTick)
                grpPh <= (grpPh == GROUP_MS - 16'h1) ? 16'h0 : grpPh + 16'h1;
            if (testRise)
                chirpPh <= 8'h0;
            else if (msTick)
                chirpPh <= (chirpPh == 8'(`SAC_CHIRP_PER_MS - 1)) ? 8'h0 : chirpPh + 8'h1;
            if (msTick)
                almPh <= (almPh == 9'(`SAC_ALM_PER_MS - 1)) ? 9'h0 : almPh + 9'h1;
        end
    end

    wire memShow = memLatch && !memExpired && !lowBatt; // [R12] [R15]
    wire memFlash = memShow && (inWin(grpPh, 16'h0) // [R11]
        || inWin(grpPh, 16'(`SAC_MEM_GAP_MS)) || inWin(grpPh, 16'(2 * `SAC_MEM_GAP_MS)));
    wire eolWarn = (ageCount >= 9'(`SAC_AGE_LIMIT));
    wire eolPulse = eolWarn && (inWin(grpPh, 16'(`SAC_EOL_OFS_MS)) // [R17] [R18]
        || inWin(grpPh, 16'(`SAC_EOL_OFS_MS + `SAC_EOL_GAP_MS))
        || inWin(grpPh, 16'(`SAC_EOL_OFS_MS + 2 * `SAC_EOL_GAP_MS)));
    wire chirp = testIn && memLatch && inWin({8'h0, chirpPh}, 16'h0); // [R13]
    wire inAlarm = (state == SAC_LOCAL) || (state == SAC_REMOTE);
    wire next_horn = inAlarm || chirp || eolPulse; // [R4] [R23]
    wire next_red = isLocal ? inWin({7'h0, almPh}, 16'h0)
        : (state == SAC_REMOTE) ? 1'b0 // [R4]
        : hush && inWin({2'h0, hushPh}, 16'h0); // [R8] [R24]

    // ----------------------------------------
    // Pin outputs
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            hornOn <= 1'b0;
            redIndicator <= 1'b0;
            memIndicator <= 1'b0;
            ioOut <= 1'b0;
            ioOeN <= 1'b1;
            ioDischarge <= 1'b0;
        end
        else
        begin
            hornOn <= next_horn; // [R6]
            redIndicator <= next_red;
            memIndicator <= memFlash;
            ioOut <= (next_state == SAC_LOCAL); // [R1]
            ioOeN <= (next_state != SAC_LOCAL); // [R1]
            ioDischarge <= localExit || (dischCnt > 11'h1); // [R3]
        end
    end

    // ----------------------------------------
    // End-of-life age count
    // ----------------------------------------
    sac_age_t ageSt;
    logic [20:0] ageSec;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ageSt <= AGE_IDLE;
            ageSec <= 21'h0;
            ageCount <= 9'h0;
            nvCmd <= '0;
        end
        else
        begin
            case (ageSt)
                AGE_IDLE:
                    if (eolEn && secTick)
                    begin
                        ageSec <= (ageSec == AGE_STEP_S - 21'h1) ? 21'h0 : ageSec + 21'h1;
                        if (ageSec == AGE_STEP_S - 21'h1)
                        begin
                            ageSt <= AGE_READ; // [R16]
                            nvCmd <= '{req: 1'b1, write: 1'b0, data: 9'h0};
                        end
                    end
                AGE_READ:
                    if (nvAck)
                    begin
                        ageCount <= nvRdata + 9'h1; // [R16]
                        ageSt <= AGE_WRITE;
                        nvCmd <= '{req: 1'b1, write: 1'b1, data: nvRdata + 9'h1};
                    end
                AGE_WRITE:
                    if (nvAck)
                    begin
                        ageSt <= AGE_IDLE;
                        nvCmd <= '0;
                    end
                default:
                    ageSt <= AGE_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Long term drift
    // ----------------------------------------
    logic [15:0] driftSec;
    logic sampleWant;
    logic [11:0] sampSum;
    logic [5:0] sampN;
    wire driftPause = hush || state != SAC_STANDBY; // [R21]
    wire [15:0] sampGap = DRIFT_SPAN_S / 16'(`SAC_DRIFT_N);
    wire takeSample = sampleWant && noSmoke && !testIn && !driftPause;
    wire [11:0] sumNext = sampSum + {6'h0, measCode};

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            driftSec <= 16'h0;
            sampleWant <= 1'b0;
            sampSum <= 12'h0;
            sampN <= 6'h0;
            drift <= 7'h0;
        end
        else
        begin
            // Clear first so a new sample request in the same cycle wins
            if (takeSample)
                sampleWant <= 1'b0;
            if (driftEn && !driftPause && secTick)
            begin
                driftSec <= (driftSec == sampGap - 16'h1) ? 16'h0 : driftSec + 16'h1;
                if (driftSec == sampGap - 16'h1)
                    sampleWant <= 1'b1; // [R19]
            end
            if (takeSample)
            begin
                sampN <= sampN + 6'h1;
                sampSum <= (sampN == 6'h3F) ? 12'h0 : sumNext; // [R19]
                if (sampN == 6'h3F)
                    drift <= {1'b0, sumNext[11:6]} - {1'b0, calBase}; // [R20]
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    wire wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    wire rdGo = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    wire wrDo = s_axi_awready;
    wire [7:0] wA = s_axi_awaddr;
    wire wrHit = (wA == `SAC_REG_CTRL) || (wA == `SAC_REG_LIMITS)
        || (wA == `SAC_REG_CALBASE);
    wire [31:0] ctrlWord = strbMerge({29'h0, ctrl}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] calWord = strbMerge({26'h0, calBase}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] statWord = {7'h0, ageCount, 1'b0, drift, remoteOk, memShow,
        eolWarn, memLatch, hush, state};
    wire [7:0] rA = s_axi_araddr;
    wire wrHitR = (rA == `SAC_REG_CTRL) || (rA == `SAC_REG_LIMITS)
        || (rA == `SAC_REG_CALBASE);
    wire rdHit = wrHitR || (rA == `SAC_REG_STATUS) || (rA == `SAC_REG_ADJLIM);
    wire [31:0] rdMux = (rA == `SAC_REG_CTRL) ? {29'h0, ctrl}
        : (rA == `SAC_REG_LIMITS) ? limWord
        : (rA == `SAC_REG_CALBASE) ? {26'h0, calBase}
        : (rA == `SAC_REG_STATUS) ? statWord
        : (rA == `SAC_REG_ADJLIM) ? 32'(lim) : 32'h0;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= `SAC_CTRL_RST;
            limWord <= `SAC_LIMITS_RST;
            calBase <= `SAC_CALBASE_RST;
        end
        else if (wrDo)
        begin
            if (wA == `SAC_REG_CTRL)
                ctrl <= ctrlWord[2:0];
            if (wA == `SAC_REG_LIMITS)
                limWord <= strbMerge(limWord, s_axi_wdata, s_axi_wstrb) & 32'h3F3F_3F3F;
            if (wA == `SAC_REG_CALBASE)
                calBase <= calWord[5:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
        end
        else
        begin
            s_axi_awready <= wrGo;
            s_axi_wready <= wrGo;
            if (wrDo)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? 2'h0 : 2'h2;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= rdGo;
            if (s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdHit ? 2'h0 : 2'h2;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// File: pkg/sac_cfg.svh
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// ----------------------------------------
// Clock and time base
// ----------------------------------------
`define SAC_CLK_NS 10
`define SAC_MS_NS 1000000
`define SAC_SEC_MS 1000

// ----------------------------------------
// Times in milliseconds
// ----------------------------------------
`define SAC_FLASH_MS 10
`define SAC_IO_FILT_MS 336
`define SAC_DISCH_MS 1300
`define SAC_HUSH_MS 540000
`define SAC_HUSH_PER_MS 10000
`define SAC_ALM_PER_MS 500
`define SAC_GROUP_MS 43000
`define SAC_MEM_GAP_MS 1300
`define SAC_CHIRP_PER_MS 250
`define SAC_EOL_OFS_MS 20000
`define SAC_EOL_GAP_MS 330

// ----------------------------------------
// Times in seconds and counts
// ----------------------------------------
`define SAC_MEM_SHOW_S 86400
`define SAC_AGE_STEP_S 1209600
`define SAC_DRIFT_SPAN_S 43200
`define SAC_DRIFT_N 64
`define SAC_AGE_LIMIT 260

// ----------------------------------------
// Register map
// ----------------------------------------
`define SAC_REG_CTRL 8'h00
`define SAC_REG_LIMITS 8'h04
`define SAC_REG_CALBASE 8'h08
`define SAC_REG_STATUS 8'h0C
`define SAC_REG_ADJLIM 8'h10
`define SAC_CTRL_EOL 0
`define SAC_CTRL_DRIFT 1
`define SAC_CTRL_HCAN 2
`define SAC_CTRL_RST 3'h0
`define SAC_LIMITS_RST 32'h1030_1820
`define SAC_CALBASE_RST 6'h10

`endif

// File: pkg/sac_pkg.sv
package sac_pkg;

    typedef enum logic [2:0] {
        SAC_STANDBY = 3'b001,
        SAC_LOCAL = 3'b010,
        SAC_REMOTE = 3'b100
    } sac_alarm_t;

    typedef enum logic [2:0] {
        AGE_IDLE = 3'b001,
        AGE_READ = 3'b010,
        AGE_WRITE = 3'b100
    } sac_age_t;

    typedef struct packed {
        logic [1:0] padC;
        logic [5:0] cht;
        logic [1:0] padH;
        logic [5:0] hush;
        logic [1:0] padY;
        logic [5:0] hyst;
        logic [1:0] padN;
        logic [5:0] norm;
    } sac_limits_t;

    typedef struct packed {
        logic req;
        logic write;
        logic [8:0] data;
    } sac_nv_cmd_t;

endpackage
